/* rtl/lip_pkg.sv */
// Package for the six bit latched I/O port: offsets, widths, resets,
// machine states and bus carriers. Assumes a plain strobe register port.
package lip_pkg;
	localparam int LIP_WIDTH = 6;
	localparam int LIP_ADDR_W = 4;
	// Register offsets
	localparam logic [3:0] LIP_OFF_DIR = 4'h0;
	localparam logic [3:0] LIP_OFF_LATCH = 4'h1;
	localparam logic [3:0] LIP_OFF_PINS = 4'h2;
	// Reset values
	localparam logic [5:0] LIP_DIR_RST = 6'h00;
	localparam logic [5:0] LIP_LATCH_RST = 6'h00;
	// Read selection codes
	localparam logic LIP_RD_PIN = 1'b0;
	localparam logic LIP_RD_LATCH = 1'b1;

	typedef enum logic [1:0] {
		LIP_MS_IDLE,
		LIP_MS_FIRST,
		LIP_MS_SECOND
	} lip_mstate_e;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
		logic rmw;
	} lip_req_s;
endpackage

/* rtl/lip_port.sv */
// Six bit general purpose port with output latch and direction register.
// Assumes one clock, a CPU master on the strobe port, raw board pins.
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/10ps

// Behaviour
// - Output latch holds written data until rewritten
// - Pin reads return live level, no capture
// - Pins sampled in first machine state
// - Latch updated in second machine state
// - Instruction class picks latch or pin read
// - Read-modify-write class reads the latch
// - All other reads of the latch offset return pin level
// - Six bidirectional port bits
// - Direction register resets to input mode
// - Output latch resets to zero
module lip_port
	import lip_pkg::*;
#(
	parameter int WIDTH = LIP_WIDTH
) (
	input wire logic i_ref_clk, // 40 MHz system clock
	input wire logic i_arst_n, // Async reset, active low
	input wire logic i_ce, // Clock enable, freezes all state
	input wire logic [3:0] i_addr, // Register offset
	input wire logic [7:0] i_wdata, // Write data
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	input wire logic i_rmw, // Read belongs to latch-reading class
	output logic [7:0] o_rdata, // Read data, cycle after strobe
	input wire logic [WIDTH-1:0] i_pin, // Pin levels from the board
	output logic [WIDTH-1:0] o_pin, // Pin output levels
	output logic [WIDTH-1:0] o_pin_oe // Pin drive enables, high drives
);

	// Widths above eight would not fit the data bus
	initial begin
		if (WIDTH < 1 || WIDTH > 8)
			$error("lip_port: WIDTH must be 1 to 8");
	end

	lip_req_s req;
	assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd,
		rmw: i_rmw};

	// Pin synchroniser; stage one only feeds stage two
	logic [WIDTH-1:0] pin_s1_reg;
	logic [WIDTH-1:0] pin_s2_reg;
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pin_s1_reg <= '0;
			pin_s2_reg <= '0;
		end else if (i_ce) begin
			pin_s1_reg <= i_pin;
			pin_s2_reg <= pin_s1_reg;
		end
	end

	// Machine state: a strobe is the first state, the cycle after the second
	lip_mstate_e ms_reg;
	lip_mstate_e ms_next;
	always_comb begin
		ms_next = LIP_MS_IDLE;
		unique case (ms_reg)
			LIP_MS_IDLE,
			LIP_MS_FIRST,
			LIP_MS_SECOND: ms_next = (req.wr || req.rd) ?
				LIP_MS_FIRST : LIP_MS_SECOND;
		endcase
		if (!(req.wr || req.rd) && ms_reg != LIP_MS_FIRST)
			ms_next = LIP_MS_IDLE;
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			ms_reg <= LIP_MS_IDLE;
		else if (i_ce)
			ms_reg <= ms_next;
	end

	// Address decode
	wire sel_dir = (req.addr == LIP_OFF_DIR);
	wire sel_latch = (req.addr == LIP_OFF_LATCH);
	wire sel_pins = (req.addr == LIP_OFF_PINS);

	// Write captured in the first state, committed in the second
	logic pend_wr_reg;
	logic pend_dir_reg;
	logic [WIDTH-1:0] pend_data_reg;
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pend_wr_reg <= 1'b0;
			pend_dir_reg <= 1'b0;
			pend_data_reg <= '0;
		end else if (i_ce) begin
			pend_wr_reg <= req.wr && (sel_latch || sel_dir);
			pend_dir_reg <= sel_dir;
			pend_data_reg <= req.wdata[WIDTH-1:0];
		end
	end

	// Direction and latch registers; hold value until rewritten
	logic [WIDTH-1:0] dir_reg;
	logic [WIDTH-1:0] latch_reg;
	wire commit = pend_wr_reg && (ms_reg == LIP_MS_FIRST);
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			dir_reg <= LIP_DIR_RST[WIDTH-1:0];
			latch_reg <= LIP_LATCH_RST[WIDTH-1:0];
		end else if (i_ce && commit) begin
			if (pend_dir_reg)
				dir_reg <= pend_data_reg;
			else
				latch_reg <= pend_data_reg;
		end
	end

	// Pin drive per bit; a one in direction drives the latch
	logic [WIDTH-1:0] pin_out_reg;
	logic [WIDTH-1:0] pin_oe_reg;
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
				if (!i_arst_n) begin
					pin_out_reg[gi] <= 1'b0;
					pin_oe_reg[gi] <= 1'b0;
				end else if (i_ce) begin
					pin_out_reg[gi] <= latch_reg[gi];
					pin_oe_reg[gi] <= dir_reg[gi];
				end
			end
		end
	endgenerate
	assign o_pin = pin_out_reg;
	assign o_pin_oe = pin_oe_reg;

	// Data read picks latch or live pin from the instruction class
	wire rd_src = req.rmw ? LIP_RD_LATCH : LIP_RD_PIN;
	wire [WIDTH-1:0] port_val = (rd_src == LIP_RD_LATCH) ?
		latch_reg : pin_s2_reg;
	wire [WIDTH-1:0] rd_sel = sel_dir ? dir_reg :
		sel_latch ? port_val :
		sel_pins ? pin_s2_reg : '0;
	// Cast pads the upper bits; a zero-width replication at eight is illegal
	wire [7:0] rd_word = 8'(rd_sel);

	// Read data stands only the cycle after the strobe
	logic [7:0] rdata_reg;
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			rdata_reg <= 8'h00;
		else if (i_ce)
			rdata_reg <= req.rd ? rd_word : 8'h00;
	end
	assign o_rdata = rdata_reg;

	// Timing overview, one strobe at a time
	// Strobe edge: request taken, machine enters first state
	// Same edge: pin sample for a read is the synchronised level
	// Same edge: write data and target parked in the pending flops
	// Next edge: second state, pending write lands in its register
	// Edge after that: pin drive and drive enable follow the register
	// Read data stands for the single cycle after the strobe edge
	// Outside that cycle the read port shows zero, never stale data
	//
	// Hazards and limits
	// Pin level reaches reads two cycles late, through the synchroniser
	// A pulse shorter than one cycle may be missed entirely
	// Chattering inputs must be filtered by software resampling
	// Board side should hold inputs steady until they are read
	// No input latch: two reads may return different levels
	// Read-modify-write class sees the latch, so set and clear bits
	// on output pins keep their intended level even under load
	// Pin-reading class on an output pin shows the wire level,
	// which can differ from the latch when the pin is overloaded
	// Offset two is read only; writes there are dropped quietly
	// Unmapped offsets read zero and ignore writes
	// Upper data bits read zero and are ignored on writes
	//
	// Back to back strobes
	// A write directly after a write commits one per cycle, in order
	// A read directly after a write sees the old value, since
	// the commit comes one edge after the strobe is taken
	// Software wanting the new value inserts one idle cycle
	// Strobes never come together; a joint write and read is
	// undefined and only the write is guaranteed to land
	//
	// Clock enable
	// Low enable freezes every flop, including the synchroniser
	// A strobe seen while enable is low is not taken at all
	// A pending write waits, frozen, until enable returns
	// Trade-off: one enable for all state keeps the timing simple,
	// at the cost of pins not being tracked while frozen
	//
	// Reset
	// Asynchronous assert clears direction, latch and pin drive
	// All pins come up as inputs, released from driving
	// First request may follow at the first edge after release
	//
	// Direction
	// A one drives the latch value onto the pin
	// A zero releases the pin to the board as an input
	// Direction and level change together at the same edge,
	// so no glitch of the old level on a newly driven pin
	// is visible beyond one cycle after the commit
	//
	// Checks below watch the internal registers next to the outputs,
	// so a fault is reported at the edge where it first appears

	// Assertions
	a_latch_holds: assert property (@(posedge i_ref_clk)
		disable iff (!i_arst_n)
		!$past(commit) && $past(i_ce) |-> $stable(latch_reg))
		else $error("latch changed without write");
	a_pin_read_live: assert property (@(posedge i_ref_clk)
		disable iff (!i_arst_n)
		i_ce && i_rd && !i_rmw && i_addr == LIP_OFF_LATCH
		|=> o_rdata[WIDTH-1:0] == $past(pin_s2_reg))
		else $error("pin read not live");
	a_rmw_latch_read: assert property (@(posedge i_ref_clk)
		disable iff (!i_arst_n)
		i_ce && i_rd && i_rmw && i_addr == LIP_OFF_LATCH
		|=> o_rdata[WIDTH-1:0] == $past(latch_reg))
		else $error("rmw read not latch");
	a_write_second: assert property (@(posedge i_ref_clk)
		disable iff (!i_arst_n)
		i_ce && i_wr && i_addr == LIP_OFF_LATCH ##1 i_ce
		|=> latch_reg == $past(i_wdata[WIDTH-1:0], 2))
		else $error("latch not written in second state");
	a_write_late: assert property (@(posedge i_ref_clk)
		disable iff (!i_arst_n)
		i_ce && i_wr && i_addr == LIP_OFF_LATCH && !commit
		|=> $stable(latch_reg))
		else $error("latch written in first state");
	a_drive_follow: assert property (@(posedge i_ref_clk)
		disable iff (!i_arst_n)
		i_ce |=> o_pin_oe == $past(dir_reg) &&
		o_pin == $past(latch_reg))
		else $error("pin drive mismatch");
	a_read_one_cycle: assert property (@(posedge i_ref_clk)
		disable iff (!i_arst_n)
		i_ce && !i_rd |=> o_rdata == 8'h00)
		else $error("read data outside answer cycle");
	a_reset_input: assert property (@(posedge i_ref_clk)
		$rose(i_arst_n) |-> dir_reg == '0 && latch_reg == '0
		&& o_pin_oe == '0)
		else $error("reset left pins driven");
	a_other_read_pin: assert property (@(posedge i_ref_clk)
		disable iff (!i_arst_n)
		i_ce && i_rd && i_addr == LIP_OFF_PINS
		|=> o_rdata[WIDTH-1:0] == $past(pin_s2_reg))
		else $error("pin register read wrong");
	// Direction write lands in the second state
	a_dir_write: assert property (@(posedge i_ref_clk)
		disable iff (!i_arst_n)
		i_ce && i_wr && i_addr == LIP_OFF_DIR ##1 i_ce
		|=> dir_reg == $past(i_wdata[WIDTH-1:0], 2))
		else $error("direction not written in second state");
	// Direction holds between writes
	a_dir_holds: assert property (@(posedge i_ref_clk)
		disable iff (!i_arst_n)
		!$past(commit) |-> $stable(dir_reg))
		else $error("direction changed without write");
	// Writes to the status offset are dropped
	a_pins_ro: assert property (@(posedge i_ref_clk)
		disable iff (!i_arst_n)
		i_ce && i_wr && i_addr == LIP_OFF_PINS
		|=> !pend_wr_reg)
		else $error("status offset accepted a write");
	// A taken strobe starts the first machine state
	a_first_state: assert property (@(posedge i_ref_clk)
		disable iff (!i_arst_n)
		i_ce && (i_wr || i_rd) |=> ms_reg == LIP_MS_FIRST)
		else $error("strobe did not start first state");
	// Low enable freezes registers and read data
	a_ce_freeze: assert property (@(posedge i_ref_clk)
		disable iff (!i_arst_n)
		!i_ce |=> $stable(dir_reg) && $stable(latch_reg)
		&& $stable(o_rdata))
		else $error("state moved while enable low");
	// Reset leaves the pin levels low
	a_reset_level: assert property (@(posedge i_ref_clk)
		$rose(i_arst_n) |-> o_pin == '0)
		else $error("reset left pin level high");

endmodule

/* verification/lip_board.sv */
// Board model driving the six port pins.
// Assumes pin drive enables are high while the port drives.
`timescale 1ns/10ps
module lip_board (
	input wire logic [5:0] i_out, // Port output level
	input wire logic [5:0] i_oe, // Port drive enable
	input wire logic [5:0] i_ext, // Board source level
	output logic [5:0] o_pin // Resolved wire level
);
	// Driven bits follow the port, released bits the board source
	assign o_pin = (i_out & i_oe) | (i_ext & ~i_oe);
endmodule

/* verification/latched_io_port_six_bit_tb.sv */
// Self-checking bench for the six bit latched port.
// Assumes lip_pkg, lip_port and lip_board are compiled first.
`timescale 1ns/10ps
module latched_io_port_six_bit_tb;
	import lip_pkg::*;
	logic clk, rst_n, ce, wr, rd, rmw;
	logic [3:0] addr;
	logic [7:0] wdata, rdata;
	logic [5:0] pin, pout, poe, ext, d, v;
	integer seed = 48;
	int failures = 0;
	int checks_done = 0;
	lip_port i_lip_port (.i_ref_clk(clk), .i_arst_n(rst_n), .i_ce(ce),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_rmw(rmw),
		.o_rdata(rdata), .i_pin(pin), .o_pin(pout), .o_pin_oe(poe));
	lip_board i_lip_board (.i_out(pout), .i_oe(poe), .i_ext(ext),
		.o_pin(pin));
	// 25 ns clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Pin read: driven bits echo the latch, upper bits zero
	function automatic logic [7:0] pexp(input logic [5:0] dd, vv, ee);
		return {2'h0, (vv & dd) | (ee & ~dd)};
	endfunction
	task automatic chk(input string nm, input logic [7:0] e, g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] dt);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= dt;
	endtask
	// Data is taken in the one cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, input logic m,
		output logic [7:0] q);
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b1;
		addr <= a;
		rmw <= m;
		@(posedge clk);
		rd <= 1'b0;
		#1 q = rdata;
	endtask
	task automatic results;
		$display("Counts: %0d checks, %0d failures", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Hang guard, about four times the expected run
	initial begin
		#100000;
		failures++;
		results();
	end
	initial begin
		logic [7:0] q;
		rst_n = 1'b0;
		ce = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		rmw = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		ext = 6'h2a;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(LIP_OFF_DIR, 1'b0, q);
		chk("dir", 8'h00, q);
		rd_reg(LIP_OFF_LATCH, 1'b1, q);
		chk("latch", 8'h00, q);
		chk("oe", 8'h00, {2'h0, poe});
		$display("Test reset done");
		// All-out, all-in, then random patterns
		for (int i = 0; i < 40; i++) begin
			d = (i == 0) ? 6'h3f : (i == 1) ? 6'h00 : 6'($random(seed));
			v = 6'($random(seed));
			wr_reg(LIP_OFF_DIR, {2'h3, d});
			wr_reg(LIP_OFF_LATCH, {2'h3, v});
			@(posedge clk);
			wr <= 1'b0;
			ext <= 6'($random(seed));
			repeat (4) @(posedge clk);
			chk("oe", {2'h0, d}, {2'h0, poe});
			chk("pin", {2'h0, v}, {2'h0, pout});
			rd_reg(LIP_OFF_LATCH, 1'b1, q);
			chk("rmw", {2'h0, v}, q);
			rd_reg(LIP_OFF_LATCH, 1'b0, q);
			chk("rd", pexp(d, v, ext), q);
			@(posedge clk);
			ext <= ~ext;
			repeat (3) @(posedge clk);
			rd_reg(LIP_OFF_PINS, 1'b0, q);
			chk("live", pexp(d, v, ext), q);
			chk("hold", {2'h0, v}, {2'h0, pout});
			rd_reg(4'h3 + 4'(i % 13), 1'b0, q);
			chk("unmap", 8'h00, q);
			wr_reg(LIP_OFF_PINS, 8'hff);
			@(posedge clk);
			ce <= 1'b0;
			wr_reg(LIP_OFF_LATCH, {2'h0, ~v});
			@(posedge clk);
			wr <= 1'b0;
			repeat (3) @(posedge clk);
			chk("freeze", {2'h0, v}, {2'h0, pout});
			ce <= 1'b1;
		end
		$display("Test random done");
		results();
	end
endmodule
